// ---- src/grmc_pkg.sv ----
// Shared constants and carrier types for the global request and mode block
package grmc_pkg;

    // ------------------------------------------------------------------
    // Serial control frame
    // ------------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 5;

    // Bit counts within a frame: 1 direction bit, 15 address, 8 data
    localparam logic [CNT_W-1:0] HDR_LAST_CNT  = 5'h0f;
    localparam logic [CNT_W-1:0] HDR_DONE_CNT  = 5'h10;
    localparam logic [CNT_W-1:0] DATA_LAST_CNT = 5'h17;
    localparam logic [CNT_W-1:0] FRAME_CNT     = 5'h18;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_REQUEST_MODE    = 15'h0001;
    localparam logic [ADDR_W-1:0] OFS_SLIP_REQUEST    = 15'h0002;
    localparam logic [ADDR_W-1:0] OFS_FUNCTION_ENABLE = 15'h0003;
    localparam logic [ADDR_W-1:0] OFS_PAIR_ENABLE     = 15'h0004;
    localparam logic [ADDR_W-1:0] OFS_STATUS          = 15'h007e;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_REQUEST_MODE    = 8'h00;
    localparam logic [DATA_W-1:0] RST_SLIP_REQUEST    = 8'h00;
    localparam logic [DATA_W-1:0] RST_FUNCTION_ENABLE = 8'h00;
    localparam logic [DATA_W-1:0] RST_PAIR_ENABLE     = 8'h00;
    localparam logic [2:0]        RST_PINS            = 3'h2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_RESEED       = 7;
    localparam int BIT_NOISE_PRIO   = 6;
    localparam int BIT_MUTE         = 3;
    localparam int BIT_PULSE_GEN    = 2;
    localparam int BIT_RESTART      = 1;
    localparam int BIT_SLEEP        = 0;
    localparam int BIT_SLIP         = 1;
    localparam int BIT_RF_RESEED    = 5;
    localparam int BIT_SYSREF_TIMER = 2;
    localparam int PAIR_W           = 7;
    localparam int NUM_CHANNELS     = 14;
    localparam int STAT_ALARM       = 4;
    localparam int STAT_REJECT      = 5;
    localparam int STAT_PENDING     = 6;

    // Sequencer state encoding that marks all earlier activity finished
    localparam logic [3:0] SEQ_STATE_DONE = 4'h2;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic reseed;
        logic pulse_gen;
        logic restart;
        logic slip;
    } grmc_events_s;

    typedef struct packed {
        logic noise_priority;
        logic mute;
        logic sleep;
        logic rf_reseed_en;
        logic sysref_timer_en;
        logic network_en;
        logic divider_run;
    } grmc_mode_s;

endpackage

// ---- src/grmc_sync2.sv ----
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module grmc_sync2 #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            meta_reg <= RST_VAL;
            o_sync   <= RST_VAL;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule // grmc_sync2
`default_nettype wire

// ---- src/grmc_rise_det.sv ----
// Rising edge detector over a vector of levels
`timescale 1ns/1ps
`default_nettype none
module grmc_rise_det #(
    parameter int W = 1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_level,
    output logic      [W-1:0] o_rise
);
    logic [W-1:0] prev_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= i_level;
        end
    end

    assign o_rise = i_level & ~prev_reg;
endmodule // grmc_rise_det
`default_nettype wire

// ---- src/grmc_global_ctrl.sv ----
// Global request, mode and output pair enable registers behind the serial port
`timescale 1ns/1ps
`default_nettype none
module grmc_global_ctrl
    import grmc_pkg::*;
(
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_reset,
    input  wire logic                    i_spi_sclk,
    input  wire logic                    i_spi_cs_n,
    input  wire logic                    i_spi_sdio,
    output logic                         o_spi_sdio,
    output logic                         o_spi_sdio_oe_n,
    input  wire logic [3:0]              i_sync_sequencer_state,
    input  wire logic                    i_slip_done,
    output var  grmc_events_s            o_event,
    output var  grmc_mode_s              o_mode,
    output logic      [NUM_CHANNELS-1:0] o_channel_en,
    output logic                         o_phase_sync_alarm
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [NUM_CHANNELS-1:0] pairs_to_channels(
        input logic [PAIR_W-1:0] pairs
    );
        logic [NUM_CHANNELS-1:0] ch;
        ch = '0;
        for (int n = 0; n < PAIR_W; n++) begin
            ch[2*n]   = pairs[n];
            ch[2*n+1] = pairs[n];
        end
        return ch;
    endfunction

    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] mode_val,
        input logic [DATA_W-1:0] slip_val,
        input logic [DATA_W-1:0] func_val,
        input logic [DATA_W-1:0] pair_val,
        input logic [DATA_W-1:0] stat_val
    );
        logic [DATA_W-1:0] rd;
        rd = '0;
        if (addr == OFS_REQUEST_MODE) begin
            rd = mode_val;
        end else if (addr == OFS_SLIP_REQUEST) begin
            rd = slip_val;
        end else if (addr == OFS_FUNCTION_ENABLE) begin
            rd = func_val;
        end else if (addr == OFS_PAIR_ENABLE) begin
            rd = pair_val;
        end else if (addr == OFS_STATUS) begin
            rd = stat_val;
        end
        return rd;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [2:0]        pins_sync;
    logic              sclk_s;
    logic              cs_n_s;
    logic              sdio_s;
    logic              sclk_prev_reg;
    logic              sclk_rise;
    logic              sclk_fall;
    logic [CNT_W-1:0]  bit_cnt_reg;
    logic [ADDR_W-1:0] shift_reg;
    logic              rw_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] rd_shift_reg;
    logic [ADDR_W-1:0] hdr_addr;
    logic              wr_en;
    logic [DATA_W-1:0] wr_data;

    logic [DATA_W-1:0] mode_reg;
    logic [DATA_W-1:0] slip_reg;
    logic [DATA_W-1:0] func_reg;
    logic [DATA_W-1:0] pair_reg;
    logic [DATA_W-1:0] status_word;

    logic [3:0]        req_level;
    logic [3:0]        req_rise;
    logic              reseed_rise;
    logic              pulse_rise;
    logic              restart_rise;
    logic              slip_rise;
    logic              seq_done;
    logic              slip_pending_reg;
    logic              reseed_reject_reg;

    // ------------------------------------------------------------------
    // Pin synchronisation and clock edges
    // ------------------------------------------------------------------
    grmc_sync2 #(
        .W       (3),
        .RST_VAL (RST_PINS)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_async   ({i_spi_sclk, i_spi_cs_n, i_spi_sdio}),
        .o_sync    (pins_sync)
    );

    assign sclk_s = pins_sync[2];
    assign cs_n_s = pins_sync[1];
    assign sdio_s = pins_sync[0];

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_reg & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_prev_reg & ~cs_n_s;

    // ------------------------------------------------------------------
    // Serial frame capture
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || cs_n_s) begin
            bit_cnt_reg <= '0;
        end else if (sclk_rise && bit_cnt_reg != FRAME_CNT) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            shift_reg <= '0;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[ADDR_W-2:0], sdio_s};
        end
    end

    assign hdr_addr = {shift_reg[ADDR_W-2:0], sdio_s};

    always_ff @(posedge i_clk_sys) begin
        if (i_reset || cs_n_s) begin
            rw_reg   <= 1'b0;
            addr_reg <= '0;
        end else if (sclk_rise && bit_cnt_reg == HDR_LAST_CNT) begin
            rw_reg   <= shift_reg[ADDR_W-1];
            addr_reg <= hdr_addr;
        end
    end

    assign wr_en   = sclk_rise && bit_cnt_reg == DATA_LAST_CNT && !rw_reg;
    assign wr_data = {shift_reg[DATA_W-2:0], sdio_s};

    // ------------------------------------------------------------------
    // Read data return
    // ------------------------------------------------------------------
    assign status_word = {1'b0, slip_pending_reg, reseed_reject_reg,
                          o_phase_sync_alarm, i_sync_sequencer_state};

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rd_shift_reg <= '0;
        end else if (sclk_rise && bit_cnt_reg == HDR_LAST_CNT) begin
            rd_shift_reg <= read_word(hdr_addr, mode_reg, slip_reg,
                                      func_reg, pair_reg, status_word);
        end else if (sclk_fall && rw_reg && bit_cnt_reg >= HDR_DONE_CNT
                     && bit_cnt_reg != FRAME_CNT) begin
            rd_shift_reg <= {rd_shift_reg[DATA_W-2:0], 1'b0};
        end
    end

    // Drive on falling edges so the host samples stable data on rising
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || cs_n_s) begin
            o_spi_sdio      <= 1'b0;
            o_spi_sdio_oe_n <= 1'b1;
        end else if (sclk_fall && rw_reg && bit_cnt_reg >= HDR_DONE_CNT
                     && bit_cnt_reg != FRAME_CNT) begin
            o_spi_sdio      <= rd_shift_reg[DATA_W-1];
            o_spi_sdio_oe_n <= 1'b0;
        end else if (sclk_fall && bit_cnt_reg == FRAME_CNT) begin
            o_spi_sdio      <= 1'b0;
            o_spi_sdio_oe_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    // Restart events never reach these registers
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            mode_reg <= RST_REQUEST_MODE;
            slip_reg <= RST_SLIP_REQUEST;
            func_reg <= RST_FUNCTION_ENABLE;
            pair_reg <= RST_PAIR_ENABLE;
        end else if (wr_en) begin
            if (addr_reg == OFS_REQUEST_MODE) begin
                mode_reg <= wr_data;
            end else if (addr_reg == OFS_SLIP_REQUEST) begin
                slip_reg <= wr_data;
            end else if (addr_reg == OFS_FUNCTION_ENABLE) begin
                func_reg <= wr_data;
            end else if (addr_reg == OFS_PAIR_ENABLE) begin
                pair_reg <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request edges
    // ------------------------------------------------------------------
    // A bit left high gives no further request until it is cleared
    assign req_level = {mode_reg[BIT_RESEED], mode_reg[BIT_PULSE_GEN],
                        mode_reg[BIT_RESTART], slip_reg[BIT_SLIP]};

    grmc_rise_det #(
        .W (4)
    ) u_req_edge (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_level   (req_level),
        .o_rise    (req_rise)
    );

    assign reseed_rise  = req_rise[3];
    assign pulse_rise   = req_rise[2];
    assign restart_rise = req_rise[1];
    assign slip_rise    = req_rise[0];
    assign seq_done     = i_sync_sequencer_state == SEQ_STATE_DONE;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_event <= '0;
        end else begin
            o_event.reseed    <= reseed_rise && seq_done;
            o_event.pulse_gen <= pulse_rise;
            o_event.restart   <= restart_rise;
            o_event.slip      <= slip_rise;
        end
    end

    // ------------------------------------------------------------------
    // Reseed rejection flag
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            reseed_reject_reg <= 1'b0;
        end else if (reseed_rise && !seq_done) begin
            reseed_reject_reg <= 1'b1;
        end else if (reseed_rise || restart_rise) begin
            reseed_reject_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Slip tracking and phase alarm
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || restart_rise) begin
            slip_pending_reg <= 1'b0;
        end else if (slip_rise) begin
            slip_pending_reg <= 1'b1;
        end else if (i_slip_done) begin
            slip_pending_reg <= 1'b0;
        end
    end

    // Completion beats a clear arriving in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_phase_sync_alarm <= 1'b0;
        end else if (slip_pending_reg && i_slip_done) begin
            o_phase_sync_alarm <= 1'b1;
        end else if (slip_rise || restart_rise) begin
            o_phase_sync_alarm <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Mode and enable outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_mode <= '0;
        end else begin
            o_mode.noise_priority  <= mode_reg[BIT_NOISE_PRIO];
            o_mode.mute            <= mode_reg[BIT_MUTE];
            o_mode.divider_run     <= ~mode_reg[BIT_SLEEP];
            o_mode.sleep           <= mode_reg[BIT_SLEEP];
            o_mode.network_en      <= ~mode_reg[BIT_SLEEP];
            o_mode.rf_reseed_en    <= func_reg[BIT_RF_RESEED];
            o_mode.sysref_timer_en <= func_reg[BIT_SYSREF_TIMER];
        end
    end

    // Muted channels keep their enable so dividers hold phase
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_channel_en <= '0;
        end else if (mode_reg[BIT_SLEEP]) begin
            o_channel_en <= '0;
        end else begin
            o_channel_en <= pairs_to_channels(pair_reg[PAIR_W-1:0]);
        end
    end

endmodule // grmc_global_ctrl
`default_nettype wire

// ---- verif/grmc_global_ctrl_chk.sv ----
// Port level assertions for the global request and mode block
`timescale 1ns/1ps
`default_nettype none
module grmc_global_ctrl_chk
    import grmc_pkg::*;
(
    input wire logic                    i_clk_sys,
    input wire logic                    i_reset,
    input wire logic                    i_spi_sclk,
    input wire logic                    i_spi_cs_n,
    input wire logic                    i_spi_sdio,
    input wire logic                    o_spi_sdio,
    input wire logic                    o_spi_sdio_oe_n,
    input wire logic [3:0]              i_sync_sequencer_state,
    input wire logic                    i_slip_done,
    input wire grmc_events_s            o_event,
    input wire grmc_mode_s              o_mode,
    input wire logic [NUM_CHANNELS-1:0] o_channel_en,
    input wire logic                    o_phase_sync_alarm
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    logic [PAIR_W-1:0] even_b;
    logic [PAIR_W-1:0] odd_b;

    // ------------------------------------------------------------------
    // Pair split of the channel enables
    // ------------------------------------------------------------------
    always_comb begin
        for (int n = 0; n < PAIR_W; n++) begin
            even_b[n] = o_channel_en[2*n];
            odd_b[n]  = o_channel_en[2*n+1];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_reseed_one_shot: assert property (o_event.reseed |=> !o_event.reseed[*3])
        else $error("reseed event longer than one cycle");
    a_reseed_needs_done: assert property (o_event.reseed |->
        $past(i_sync_sequencer_state) == SEQ_STATE_DONE)
        else $error("reseed issued while sequencer not done");
    a_pulse_one_shot: assert property (o_event.pulse_gen |=> !o_event.pulse_gen[*3])
        else $error("pulse request event longer than one cycle");
    a_slip_one_shot: assert property (o_event.slip |=> !o_event.slip[*3])
        else $error("slip event longer than one cycle");
    a_alarm_cause: assert property ($rose(o_phase_sync_alarm) |-> $past(i_slip_done))
        else $error("alarm rose without slip completion");
    a_restart_keeps: assert property (o_event.restart |=>
        $stable(o_mode) && $stable(o_channel_en))
        else $error("restart altered configuration outputs");
    a_pair_together: assert property (even_b == odd_b)
        else $error("channels of one pair differ");
    a_sleep_gates: assert property (o_mode.sleep |-> o_channel_en == '0 &&
        !o_mode.network_en && !o_mode.divider_run)
        else $error("sleep left network running");
    a_mute_runs: assert property (o_mode.mute && !o_mode.sleep |-> o_mode.divider_run)
        else $error("mute stopped the dividers");
    a_oe_idle: assert property (i_spi_cs_n[*8] |-> o_spi_sdio_oe_n)
        else $error("data pin driven while deselected");

    c_reseed: cover property (o_event.reseed);
    c_restart: cover property (o_event.restart);
    c_alarm: cover property ($rose(o_phase_sync_alarm));
    c_sleep: cover property (o_mode.sleep);
endmodule // grmc_global_ctrl_chk

bind grmc_global_ctrl grmc_global_ctrl_chk i_grmc_global_ctrl_chk (
    .i_clk_sys, .i_reset, .i_spi_sclk, .i_spi_cs_n, .i_spi_sdio, .o_spi_sdio,
    .o_spi_sdio_oe_n, .i_sync_sequencer_state, .i_slip_done, .o_event,
    .o_mode, .o_channel_en, .o_phase_sync_alarm);
`default_nettype wire

// ---- verif/test_global_request_mode_control.sv ----
// Self-checking bench for the global request and mode block
`timescale 1ns/1ps
`default_nettype none
module test_global_request_mode_control
    import grmc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, sclk = 1'b0, cs_n = 1'b1, sdi = 1'b0;
    logic sdo, oe_n, done = 1'b0, alarm;
    logic [3:0] seq = SEQ_STATE_DONE;
    logic [NUM_CHANNELS-1:0] ch;
    logic [7:0] q;
    grmc_events_s ev;
    grmc_mode_s md;
    int err_total = 0, checks = 0, n_rs = 0, n_pg = 0, n_rt = 0, n_sl = 0;

    initial forever #25 clk = ~clk;

    grmc_global_ctrl i_grmc_global_ctrl (.i_clk_sys(clk), .i_reset(rst),
        .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_sdio(sdi),
        .o_spi_sdio(sdo), .o_spi_sdio_oe_n(oe_n), .i_sync_sequencer_state(seq),
        .i_slip_done(done), .o_event(ev), .o_mode(md), .o_channel_en(ch),
        .o_phase_sync_alarm(alarm));

    // Event pulses are one cycle wide, so count them on every falling edge
    always @(negedge clk) begin
        if (!rst) begin
            n_rs += ev.reseed;
            n_pg += ev.pulse_gen;
            n_rt += ev.restart;
            n_sl += ev.slip;
        end
    end

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Serial port, mode 0, msb first; nb below 24 aborts the frame
    // ------------------------------------------------------------------
    task automatic spi(input logic rw, input logic [14:0] a,
                       input logic [7:0] d, input int nb);
        logic [23:0] w;
        w = {rw, a, d};
        q = 8'h00;
        @(negedge clk) cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 23; i > 23 - nb; i--) begin
            sdi = w[i];
            repeat (5) @(negedge clk);
            if (i < 8) q[i] = sdo;
            sclk = 1'b1;
            repeat (5) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (5) @(negedge clk);
        cs_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        spi(1'b0, a, d, 24);
    endtask

    task automatic rd(input logic [14:0] a);
        spi(1'b1, a, 8'h00, 24);
    endtask

    task automatic slip_done_pulse();
        done = 1'b1;
        @(negedge clk) done = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_reset();
        chk({9'h000, md}, 16'h0003);
        chk(ch, 16'h0000);
        chk(oe_n, 16'h0001);
        for (int a = 1; a <= 4; a++) begin
            rd(15'(a));
            chk(q, 16'h0000);
        end
        wr(15'h0010, 8'h5a);
        rd(15'h0010);
        chk(q, 16'h0000);
    endtask

    task automatic sc_levels();
        for (int n = 0; n < PAIR_W; n++) begin
            wr(OFS_PAIR_ENABLE, 8'(1 << n));
            chk(ch, 16'h0003 << (2 * n));
        end
        wr(OFS_PAIR_ENABLE, 8'h7f);
        wr(OFS_FUNCTION_ENABLE, 8'h24);
        chk({md.rf_reseed_en, md.sysref_timer_en}, 16'h0003);
        wr(OFS_FUNCTION_ENABLE, 8'h00);
        chk({md.rf_reseed_en, md.sysref_timer_en}, 16'h0000);
        wr(OFS_REQUEST_MODE, 8'h48);
        chk({md.noise_priority, md.mute, md.divider_run}, 16'h0007);
        chk(ch, 16'h3fff);
        wr(OFS_REQUEST_MODE, 8'h01);
        chk({ch, md.network_en, md.divider_run}, 16'h0000);
        chk(md.sleep, 16'h0001);
        wr(OFS_REQUEST_MODE, 8'h00);
        chk({ch, md.noise_priority}, 16'h7ffe);
        spi(1'b0, OFS_PAIR_ENABLE, 8'h00, 12);
        chk(ch, 16'h3fff);
    endtask

    task automatic sc_reseed();
        wr(OFS_REQUEST_MODE, 8'h80);
        chk(16'(n_rs), 16'h0001);
        wr(OFS_REQUEST_MODE, 8'h80);
        chk(16'(n_rs), 16'h0001);
        wr(OFS_REQUEST_MODE, 8'h00);
        seq = 4'h5;
        wr(OFS_REQUEST_MODE, 8'h80);
        chk(16'(n_rs), 16'h0001);
        rd(OFS_STATUS);
        chk(q[STAT_REJECT], 16'h0001);
        chk(q, 16'h0025);
        wr(OFS_REQUEST_MODE, 8'h00);
        seq = SEQ_STATE_DONE;
        wr(OFS_REQUEST_MODE, 8'h80);
        chk(16'(n_rs), 16'h0002);
        wr(OFS_REQUEST_MODE, 8'h04);
        chk(16'(n_pg), 16'h0001);
    endtask

    task automatic sc_slip_restart();
        wr(OFS_FUNCTION_ENABLE, 8'h24);
        wr(OFS_SLIP_REQUEST, 8'h02);
        chk(16'(n_sl), 16'h0001);
        chk(alarm, 16'h0000);
        slip_done_pulse();
        chk(alarm, 16'h0001);
        wr(OFS_SLIP_REQUEST, 8'h00);
        wr(OFS_SLIP_REQUEST, 8'h02);
        chk({15'(n_sl), alarm}, 16'h0004);
        slip_done_pulse();
        wr(OFS_REQUEST_MODE, 8'h02);
        chk({15'(n_rt), alarm}, 16'h0002);
        rd(OFS_FUNCTION_ENABLE);
        chk(q, 16'h0024);
        rd(OFS_PAIR_ENABLE);
        chk(q, 16'h007f);
        rd(OFS_REQUEST_MODE);
        chk(q, 16'h0002);
        chk({md.rf_reseed_en, ch}, 16'h7fff);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        sc_reset();
        sc_levels();
        sc_reseed();
        sc_slip_restart();
        complete_run();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule // test_global_request_mode_control
`default_nettype wire
